/* row_maintenance_sequencer.sv */
// row maintenance sequencer: activation counts, targeted refresh, repair
//
// How it works
// - each activate adds one, saturating at all ones; lowering floored at zero
// - threshold and multiplier advertised, limit is threshold*(multiplier+1)
// - extra refresh lowers threshold*(decrement+2)/2, refresh threshold
// - unlimited count: enabling targeted refresh is ignored
// - bit 7 enables targeted refresh, 6:4 bank
// - enable self-clears after third precharge plus delay
// - three activate/precharge pairs, precharge-all counts
// - repair capability readable, one row per bank
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module row_maintenance_sequencer
  import row_maint_pkg::*;
#(
  parameter int NUM_BANKS = 8,
  parameter int CNT_W = 12,
  parameter int THRESH_UNIT = 8,
  parameter logic [2:0] CAP_MAC = 3'h0,
  parameter logic CAP_UNLIMITED = 1'b0,
  parameter logic [4:0] CAP_THRESHOLD = 5'h14,
  parameter logic [1:0] CAP_MULT = 2'h3,
  parameter logic CAP_MGMT_REQ = 1'b1,
  parameter logic [7:0] CAP_REPAIR = 8'hFF,
  parameter int REG_SET_DELAY_NS = 20,
  parameter int PRECHARGE_NS = 20,
  parameter int PROGRAM_CYC = PROGRAM_CYC_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_type,
  input wire logic [2:0] cmd_bank,
  input wire logic cmd_all_bank,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NUM_BANKS-1:0] bank_blocked,
  output logic trr_active,
  output logic repair_reset_request
);

  localparam int MRD_CYC =
    (REG_SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MRD_C = (MRD_CYC < 1) ? 1 : MRD_CYC;
  localparam int CLOSE_C = RP_CYC + MRD_C;
  localparam int EXIT_C = (REPAIR_EXIT_CYC < 1) ? 1 : REPAIR_EXIT_CYC;

  if (NUM_BANKS != 8 || CNT_W < 10 || CNT_W > 16 || PROGRAM_CYC < 1)
  begin : g_bad_params
    $error("row_maintenance_sequencer: unsupported parameters");
  end

  // ==========================================================
  // command decode
  wire act_cmd = cmd_valid && cmd_type == CMD_ACT;
  wire pre_cmd = cmd_valid && cmd_type == CMD_PRE;
  wire precharge_all_cmd_cmd = cmd_valid && cmd_type == CMD_PRECHARGE_ALL_CMD;
  wire ref_cmd = cmd_valid && cmd_type == CMD_REF;
  wire rfm_cmd = cmd_valid && cmd_type == CMD_RFM && CAP_MGMT_REQ;

  // ==========================================================
  // software-visible control
  logic [1:0] decrement_q;
  logic repair_en_q;
  logic [2:0] sel_bank_q;
  trr_state_t trr_q;
  logic [1:0] trr_pre_cnt_q;
  logic [1:0] trr_act_cnt_q;
  logic [15:0] trr_timer_q;
  ppr_state_t ppr_q;
  logic [31:0] ppr_timer_q;
  logic [2:0] ppr_bank_q;
  logic [NUM_BANKS-1:0] repaired_q;

  // ==========================================================
  // activation counters
  wire [CNT_W-1:0] threshold = CNT_W'(CAP_THRESHOLD * THRESH_UNIT);
  // limit = threshold times (multiplier field + 1)
  wire [CNT_W-1:0] limit = CNT_W'(threshold * (CAP_MULT + 3'h1));
  wire [CNT_W-1:0] rfm_amount =
    CNT_W'((threshold * (decrement_q + 3'h2)) >> 1);
  logic [CNT_W-1:0] counts [NUM_BANKS];

  for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
    wire hit = cmd_bank == 3'(i) || cmd_all_bank;
    bank_activation_counter #(.CNT_W(CNT_W)) u_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .act_hit(act_cmd && cmd_bank == 3'(i)),
      .ref_hit(ref_cmd && hit),
      .rfm_hit(rfm_cmd && hit),
      .ref_amount(threshold),
      .rfm_amount(rfm_amount),
      .limit(limit),
      .count_q(counts[i]),
      .blocked_q(bank_blocked[i])
    );
  end

  // ==========================================================
  // register bus: write channel
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] waddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire aw_have_d = (aw_have_q && !wr_fire) || aw_take;
  wire w_have_d = (w_have_q && !wr_fire) || w_take;
  wire wr_known = waddr_q == ROW_HAMMER_OFS || waddr_q == REFRESH_RATE_OFS ||
                  waddr_q == DECREMENT_OFS;
  wire wr_en = wr_fire && wr_known && wlane_q;
  wire rh_write = wr_en && waddr_q == ROW_HAMMER_OFS;
  wire trr_enable_wr = rh_write && wbyte_q[TRR_EN_BIT];
  wire trr_abort_wr = rh_write && !wbyte_q[TRR_EN_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      waddr_q <= 8'h00;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      s_axi_awready <= !aw_have_d;
      s_axi_wready <= !w_have_d;
      if (aw_take) waddr_q <= s_axi_awaddr;
      if (w_take) begin
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      decrement_q <= DECREMENT_RST;
      repair_en_q <= 1'b0;
    end else if (wr_en && waddr_q == DECREMENT_OFS) begin
      decrement_q <= wbyte_q[1:0];
    end else if (wr_en && waddr_q == REFRESH_RATE_OFS) begin
      repair_en_q <= wbyte_q[REPAIR_EN_BIT];
    end
  end

  // ==========================================================
  // targeted row refresh
  wire sel_pre = (pre_cmd && cmd_bank == sel_bank_q) || precharge_all_cmd_cmd;
  wire sel_act = act_cmd && cmd_bank == sel_bank_q;
  // unlimited count: entry ignored
  wire unlimited = CAP_MAC == 3'h0 && CAP_UNLIMITED;
  wire trr_start = trr_enable_wr && trr_q == TRR_IDLE && !unlimited;
  wire trr_timer_done = trr_timer_q == 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trr_q <= TRR_IDLE;
      trr_pre_cnt_q <= 2'h0;
      trr_act_cnt_q <= 2'h0;
      trr_timer_q <= 16'h0000;
      sel_bank_q <= 3'h0;
    end else if (trr_abort_wr || trr_start) begin
      // abort or entry restarts progress
      trr_q <= trr_start ? TRR_ENTRY : TRR_IDLE;
      trr_pre_cnt_q <= 2'h0;
      trr_act_cnt_q <= 2'h0;
      trr_timer_q <= 16'(MRD_C - 1);
      if (trr_start) sel_bank_q <= wbyte_q[TRR_BANK_LSB +: 3];
    end else begin
      case (trr_q)
        TRR_ENTRY: begin
          trr_timer_q <= trr_timer_q - 16'h0001;
          if (trr_timer_done) trr_q <= TRR_RUN;
        end
        TRR_RUN: begin
          if (sel_act && trr_act_cnt_q != 2'h3)
            trr_act_cnt_q <= trr_act_cnt_q + 2'h1;
          if (sel_pre) begin
            trr_pre_cnt_q <= trr_pre_cnt_q + 2'h1;
            if (trr_pre_cnt_q == 2'h2) begin
              trr_q <= TRR_CLOSE;
              trr_timer_q <= 16'(CLOSE_C - 1);
            end
          end
        end
        TRR_CLOSE: begin
          trr_timer_q <= trr_timer_q - 16'h0001;
          if (trr_timer_done) begin
            trr_q <= TRR_IDLE;
            trr_pre_cnt_q <= 2'h0;
            trr_act_cnt_q <= 2'h0;
          end
        end
        default: trr_q <= TRR_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) trr_active <= 1'b0;
    else trr_active <= !(trr_abort_wr || (trr_q == TRR_CLOSE && trr_timer_done))
                       && (trr_start || trr_q != TRR_IDLE);
  end

  // ==========================================================
  // post package repair
  wire ppr_timer_done = ppr_timer_q == 32'h0000_0000;
  wire ppr_pre = pre_cmd || precharge_all_cmd_cmd;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ppr_q <= PPR_OFF;
      ppr_timer_q <= 32'h0000_0000;
      ppr_bank_q <= 3'h0;
      repaired_q <= '0;
    end else begin
      if (ppr_timer_q != 32'h0000_0000)
        ppr_timer_q <= ppr_timer_q - 32'h0000_0001;
      case (ppr_q)
        PPR_OFF: if (repair_en_q && CAP_REPAIR != 8'h00) begin
          ppr_q <= PPR_SETUP;
          ppr_timer_q <= 32'(MRD_C - 1);
        end
        PPR_SETUP: if (!repair_en_q) ppr_q <= PPR_OFF;
          else if (ppr_timer_done) ppr_q <= PPR_ARMED;
        PPR_ARMED: if (!repair_en_q) ppr_q <= PPR_OFF;
          else if (act_cmd && !repaired_q[cmd_bank]) begin
            ppr_q <= PPR_PROGRAM;
            ppr_bank_q <= cmd_bank;
            ppr_timer_q <= 32'(PROGRAM_CYC - 1);
          end
        PPR_PROGRAM: if (ppr_pre) begin
          // precharge before programming time ends loses the repair
          ppr_q <= ppr_timer_done ? PPR_EXIT : PPR_ARMED;
          ppr_timer_q <= 32'(EXIT_C - 1);
          if (ppr_timer_done) repaired_q[ppr_bank_q] <= 1'b1;
        end
        PPR_EXIT: if (ppr_timer_done) ppr_q <= PPR_HOLD;
        PPR_HOLD: if (!repair_en_q) begin
          ppr_q <= PPR_POST;
          ppr_timer_q <= 32'(NEW_ADDR_CYC - 1);
        end
        PPR_POST: if (ppr_timer_done) ppr_q <= PPR_RESET_REQ;
        PPR_RESET_REQ: ppr_q <= PPR_RESET_REQ;
        default: ppr_q <= PPR_OFF;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) repair_reset_request <= 1'b0;
    else repair_reset_request <= ppr_q == PPR_RESET_REQ;
  end

  // ==========================================================
  // register bus: read channel
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [7:0] ra = s_axi_araddr;
  wire ra_count = ra >= COUNT_BASE_OFS &&
                  ra < COUNT_BASE_OFS + 8'(4 * NUM_BANKS) && ra[1:0] == 2'h0;
  wire [2:0] ra_bank = 3'((ra - COUNT_BASE_OFS) >> 2);
  wire [31:0] cap_word = {20'h00000, CAP_MGMT_REQ, CAP_MULT, CAP_THRESHOLD,
                          CAP_UNLIMITED, CAP_MAC};
  wire [31:0] status_word = {repaired_q, ppr_q, 7'h00, trr_act_cnt_q,
                             trr_pre_cnt_q, trr_q, trr_active};
  wire [31:0] rh_word = {24'h000000, trr_active, sel_bank_q, 4'h0};
  wire rd_known = ra == ROW_HAMMER_OFS || ra == REPAIR_CAP_OFS ||
                  ra == REFRESH_RATE_OFS || ra == DECREMENT_OFS ||
                  ra == CAPABILITY_OFS || ra == STATUS_OFS || ra_count;
  wire [31:0] rd_word =
    ra == ROW_HAMMER_OFS ? rh_word :
    ra == REPAIR_CAP_OFS ? {24'h000000, CAP_REPAIR} :
    ra == REFRESH_RATE_OFS ? 32'(repair_en_q) << REPAIR_EN_BIT :
    ra == DECREMENT_OFS ? {30'h00000000, decrement_q} :
    ra == CAPABILITY_OFS ? cap_word :
    ra == STATUS_OFS ? status_word :
    ra_count ? 32'(counts[ra_bank]) : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // row_maintenance_sequencer
`default_nettype wire

/* row_maint_pkg.sv */
// shared constants for the row maintenance sequencer
package row_maint_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ROW_HAMMER_OFS = 8'h00;
  localparam logic [7:0] REPAIR_CAP_OFS = 8'h04;
  localparam logic [7:0] REFRESH_RATE_OFS = 8'h08;
  localparam logic [7:0] DECREMENT_OFS = 8'h0C;
  localparam logic [7:0] CAPABILITY_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] COUNT_BASE_OFS = 8'h20;

  // ==========================================================
  // field positions
  localparam int TRR_EN_BIT = 7;
  localparam int TRR_BANK_LSB = 4;
  localparam int REPAIR_EN_BIT = 4;
  localparam int CAP_UNLIM_BIT = 3;
  localparam int CAP_THR_LSB = 4;
  localparam int CAP_MULT_LSB = 9;
  localparam int CAP_REQ_BIT = 11;

  // ==========================================================
  // reset value and bus response codes
  localparam logic [1:0] DECREMENT_RST = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int REPAIR_EXIT_NS = 15;
  localparam int NEW_ADDR_US = 50;
  localparam int PROGRAM_MS = 1000;
  localparam int REPAIR_EXIT_CYC =
    (REPAIR_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NEW_ADDR_CYC =
    (NEW_ADDR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_CYC_DEF =
    (PROGRAM_MS * 1000000) / CLK_PERIOD_NS;

  // ==========================================================
  // commands seen on the command/address bus
  typedef enum logic [2:0] {
    CMD_ACT = 3'h0,
    CMD_PRE = 3'h1,
    CMD_PRECHARGE_ALL_CMD = 3'h2,
    CMD_REF = 3'h3,
    CMD_RFM = 3'h4,
    CMD_OTHER = 3'h7
  } cmd_t;

  typedef enum logic [3:0] {
    TRR_IDLE = 4'b0001,
    TRR_ENTRY = 4'b0010,
    TRR_RUN = 4'b0100,
    TRR_CLOSE = 4'b1000
  } trr_state_t;

  typedef enum logic [7:0] {
    PPR_OFF = 8'b0000_0001,
    PPR_SETUP = 8'b0000_0010,
    PPR_ARMED = 8'b0000_0100,
    PPR_PROGRAM = 8'b0000_1000,
    PPR_EXIT = 8'b0001_0000,
    PPR_HOLD = 8'b0010_0000,
    PPR_POST = 8'b0100_0000,
    PPR_RESET_REQ = 8'b1000_0000
  } ppr_state_t;

endpackage

/* bank_activation_counter.sv */
// per-bank rolling activation counter with blocking flag
`timescale 1ns/1ns
`default_nettype none
module bank_activation_counter #(
  parameter int CNT_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic act_hit,
  input wire logic ref_hit,
  input wire logic rfm_hit,
  input wire logic [CNT_W-1:0] ref_amount,
  input wire logic [CNT_W-1:0] rfm_amount,
  input wire logic [CNT_W-1:0] limit,
  output logic [CNT_W-1:0] count_q,
  output logic blocked_q
);

  logic [CNT_W-1:0] amount;
  logic [CNT_W-1:0] lowered;
  logic [CNT_W-1:0] count_d;

  assign amount = rfm_hit ? rfm_amount : ref_amount;
  // floor at zero, never negative
  assign lowered = (count_q > amount) ? count_q - amount : '0;
  // extra-refresh uses threshold times (decrement + 2) / 2, refresh threshold
  assign count_d = (rfm_hit || ref_hit) ? lowered :
                   (act_hit && count_q != '1) ? count_q + 1'b1 : count_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
      blocked_q <= 1'b0;
    end else begin
      count_q <= count_d;
      blocked_q <= (limit != '0) && (count_d >= limit);
    end
  end

endmodule // bank_activation_counter
`default_nettype wire

/* row_maint_checker.sv */
// port assertions for the row maintenance sequencer
`timescale 1ns/1ns
`default_nettype none
module row_maint_checker
  import row_maint_pkg::*;
#(
  parameter int NUM_BANKS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_type,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_BANKS-1:0] bank_blocked,
  input wire logic trr_active,
  input wire logic repair_reset_request
);
  // ====
  // helpers: precharges seen in the mode, cycles since a write landed
  logic [1:0] pre_cnt_q;
  logic [10:0] since_q;
  wire logic pre_evt;
  assign pre_evt = cmd_valid && (cmd_type == CMD_PRE || cmd_type == CMD_PRECHARGE_ALL_CMD);
  always_ff @(posedge aclk) begin
    if (!aresetn || !trr_active) pre_cnt_q <= 2'h0;
    else if (pre_evt && pre_cnt_q != 2'h3) pre_cnt_q <= pre_cnt_q + 2'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || $rose(s_axi_bvalid)) since_q <= 11'h000;
    else if (since_q != 11'h7FF) since_q <= since_q + 11'h001;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ====
  // assertions
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("address taken twice");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_block_cause: assert property (|(bank_blocked & ~$past(bank_blocked))
    |-> $past(cmd_valid) && $past(cmd_type) == CMD_ACT)
    else $error("bank blocked without activate");
  a_unblock_cause: assert property (|(~bank_blocked & $past(bank_blocked))
    |-> $past(cmd_valid) && ($past(cmd_type) == CMD_REF ||
    $past(cmd_type) == CMD_RFM)) else $error("bank freed without refresh");
  a_trr_entry: assert property ($rose(trr_active) |-> s_axi_bvalid)
    else $error("targeted refresh began without write");
  a_trr_done: assert property (trr_active && pre_evt && pre_cnt_q == 2'h2
    |-> ##[1:4] !trr_active) else $error("targeted refresh kept");
  a_trr_hold: assert property (trr_active && pre_cnt_q != 2'h3 &&
    !(pre_evt && pre_cnt_q == 2'h2) && s_axi_wready && !s_axi_wvalid
    |=> trr_active) else $error("targeted refresh ended early");
  a_req_sticky: assert property (repair_reset_request |=>
    repair_reset_request) else $error("reset request dropped");
  a_req_delay: assert property ($rose(repair_reset_request) |->
    since_q >= 11'd995 && since_q <= 11'd1005) else $error("reset req time");
endmodule // row_maint_checker
`default_nettype wire

/* mem_ctrl_model.sv */
// memory controller model driving the command bus
`timescale 1ns/1ns
`default_nettype none
module mem_ctrl_model
  import row_maint_pkg::*;
(
  input wire logic aclk,
  input wire logic [7:0] bank_blocked,
  input wire logic trr_active,
  output logic cmd_valid,
  output logic [2:0] cmd_type,
  output logic [2:0] cmd_bank,
  output logic cmd_all_bank
);
  int skipped = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_type = 3'h7;
    cmd_bank = 3'h0;
    cmd_all_bank = 1'b0;
  end
  // one command cycle, then a gap with the lines inverted
  task automatic issue(input cmd_t t, input logic [2:0] b, input logic all);
    if ((t == CMD_ACT && bank_blocked[b]) ||
        (t == CMD_REF && trr_active)) begin
      skipped++;
    end else begin
      cmd_valid <= 1'b1;
      cmd_type <= t;
      cmd_bank <= b;
      cmd_all_bank <= all;
      @(posedge aclk);
      cmd_valid <= 1'b0;
      cmd_type <= ~t;
      cmd_bank <= ~b;
      cmd_all_bank <= ~all;
      @(posedge aclk);
    end
  endtask
  // open the aggressor row, hold it, close it
  task automatic act_pre(input logic [2:0] b, input int open, input cmd_t p);
    issue(CMD_ACT, b, 1'b0);
    repeat (open) @(posedge aclk);
    issue(p, b, 1'b0);
  endtask
endmodule // mem_ctrl_model
`default_nettype wire

/* tb_row_maintenance_sequencer.sv */
// self-checking bench for the row maintenance sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_row_maintenance_sequencer
  import row_maint_pkg::*;
;
  localparam int THR = 16;
  localparam int LIMIT = 64;
  localparam int PROG_CYC = 20;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [7:0] BANK2 = COUNT_BASE_OFS + 8'h08;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, bank_blocked;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cmd_valid, cmd_all_bank, trr_active, repair_reset_request;
  logic [2:0] cmd_type, cmd_bank;
  int err_count = 0;
  int samples_checked = 0;
  row_maintenance_sequencer #(.CAP_THRESHOLD(5'h02), .PROGRAM_CYC(PROG_CYC))
  dut (.aclk, .aresetn, .cmd_valid, .cmd_type, .cmd_bank, .cmd_all_bank,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .bank_blocked, .trr_active,
    .repair_reset_request);
  mem_ctrl_model ctl (.aclk, .bank_blocked, .trr_active, .cmd_valid,
    .cmd_type, .cmd_bank, .cmd_all_bank);
  // ====
  // shared tasks
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    check("bvalid", 1'b1, s_axi_bvalid);
    check("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    check("rdata", exp, s_axi_rdata & m);
    check("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // ====
  // scenarios
  task automatic t_regs();
    rd_chk(CAPABILITY_OFS, ALL, 32'h00000E20, RESP_OKAY);
    rd_chk(REPAIR_CAP_OFS, ALL, 32'h000000FF, RESP_OKAY);
    rd_chk(DECREMENT_OFS, ALL, {30'h0, DECREMENT_RST}, RESP_OKAY);
    rd_chk(8'h18, ALL, 32'h0, RESP_SLVERR);
    axi_wr(REPAIR_CAP_OFS, 32'h0, RESP_SLVERR);
    rd_chk(REPAIR_CAP_OFS, ALL, 32'h000000FF, RESP_OKAY);
    $display("test regs done");
  endtask
  task automatic t_count();
    repeat (LIMIT) ctl.issue(CMD_ACT, 3'h2, 1'b0);
    check("blocked", 1'b1, bank_blocked[2]);
    rd_chk(BANK2, ALL, LIMIT, RESP_OKAY);
    ctl.issue(CMD_RFM, 3'h2, 1'b0);
    check("blocked", 1'b0, bank_blocked[2]);
    rd_chk(BANK2, ALL, LIMIT - 2 * THR, RESP_OKAY);
    ctl.issue(CMD_REF, 3'h2, 1'b0);
    rd_chk(BANK2, ALL, LIMIT - 3 * THR, RESP_OKAY);
    axi_wr(DECREMENT_OFS, 32'h0, RESP_OKAY);
    ctl.issue(CMD_RFM, 3'h0, 1'b1);
    rd_chk(BANK2, ALL, 32'h0, RESP_OKAY);
    ctl.issue(CMD_REF, 3'h0, 1'b1);
    rd_chk(BANK2, ALL, 32'h0, RESP_OKAY);
    $display("test counter done");
  endtask
  task automatic t_trr();
    axi_wr(ROW_HAMMER_OFS, 32'h000000B0, RESP_OKAY);
    check("trr_on", 1'b1, trr_active);
    repeat (2) @(posedge aclk);
    ctl.act_pre(3'h3, 3, CMD_PRE);
    axi_wr(ROW_HAMMER_OFS, 32'h0, RESP_OKAY);
    check("trr_on", 1'b0, trr_active);
    repeat (3) ctl.issue(CMD_PRE, 3'h3, 1'b0);
    axi_wr(ROW_HAMMER_OFS, 32'h000000B0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    ctl.act_pre(3'h3, 3, CMD_PRE);
    ctl.act_pre(3'h3, 2, CMD_PRE);
    check("trr_on", 1'b1, trr_active);
    ctl.act_pre(3'h3, 2, CMD_PRECHARGE_ALL_CMD);
    repeat (4) @(posedge aclk);
    check("trr_on", 1'b0, trr_active);
    rd_chk(ROW_HAMMER_OFS, 32'h00000080, 32'h0, RESP_OKAY);
    check("skipped", 32'h0, ctl.skipped);
    $display("test targeted refresh done");
  endtask
  task automatic t_repair();
    ctl.issue(CMD_PRECHARGE_ALL_CMD, 3'h0, 1'b1);
    axi_wr(REFRESH_RATE_OFS, 32'h00000010, RESP_OKAY);
    repeat (2) @(posedge aclk);
    ctl.issue(CMD_ACT, 3'h1, 1'b0);
    repeat (PROG_CYC + 2) @(posedge aclk);
    ctl.issue(CMD_PRE, 3'h1, 1'b0);
    repeat (2) @(posedge aclk);
    axi_wr(REFRESH_RATE_OFS, 32'h0, RESP_OKAY);
    repeat (NEW_ADDR_CYC - 20) @(posedge aclk);
    check("reset_req", 1'b0, repair_reset_request);
    repeat (40) @(posedge aclk);
    check("reset_req", 1'b1, repair_reset_request);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("reset_req", 1'b0, repair_reset_request);
    $display("test repair done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ====
  // clock, watchdog, main sequence
  initial begin
    aclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  end
  initial begin
    #(CLK_PERIOD_NS * 6000);
    err_count++;
    stop_test();
  end
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_count();
    t_trr();
    t_repair();
    stop_test();
  end
endmodule // tb_row_maintenance_sequencer
bind row_maintenance_sequencer row_maint_checker #(.NUM_BANKS(NUM_BANKS))
u_chk (.aclk, .aresetn, .cmd_valid, .cmd_type, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .bank_blocked, .trr_active, .repair_reset_request);
`default_nettype wire
